// ---- logic/mode_pages_pkg.sv ----
package mode_pages_pkg;
  // Page identity and lengths
  localparam logic [5:0] notch_page_code   = 6'h0c;
  localparam logic [7:0] notch_page_len    = 8'h16;
  localparam logic [5:0] port_page_code    = 6'h19;
  localparam logic [7:0] port_page_len     = 8'h06;
  localparam logic [5:0] power_page_code   = 6'h1a;
  localparam logic [7:0] power_page_len    = 8'h0a;
  // Notch page fixed values
  localparam logic [15:0] max_zones        = 16'h000b;
  localparam logic [63:0] pages_notched    = 64'h0000_0000_0000_000c;
  localparam logic       zoned_unit_val    = 1'b1;
  localparam logic       logical_basis_val = 1'b0;
  // Port page protocol identifier
  localparam logic [3:0] protocol_id       = 4'h1;
  // Page byte offsets of the writable / reported fields
  localparam logic [4:0] notch_flags_byte  = 5'h02;
  localparam logic [4:0] active_zone_hi    = 5'h06;
  localparam logic [4:0] active_zone_lo    = 5'h07;
  localparam logic [4:0] start_bound_byte  = 5'h08;
  localparam logic [4:0] end_bound_byte    = 5'h0c;
  localparam logic [4:0] notched_map_byte  = 5'h10;
  localparam logic [4:0] port_proto_byte   = 5'h03;
  localparam logic [4:0] power_ctl_byte    = 5'h03;
  localparam logic [4:0] idle_timer_byte   = 5'h04;
  localparam logic [4:0] standby_tmr_byte  = 5'h08;
  // Field positions in power byte 3
  localparam int         idle_bit_pos      = 1;
  localparam int         standby_bit_pos   = 0;
  // Timing: standby timer unit and floor
  localparam int         clk_period_ns     = 10;
  localparam int         tick_unit_ms      = 100;
  localparam int         tick_cycles       = tick_unit_ms * 1000000 / clk_period_ns;
  localparam int         standby_floor_min = 60;
  localparam logic [31:0] standby_floor_ticks = 32'(standby_floor_min * 60 * 1000 / tick_unit_ms);
endpackage

// ---- logic/notch_port_power_mode_pages.sv ----
`timescale 1ns/1ns
// Functional notes
// - Notch page reports the zoned unit flag as one.
// - Notch page reports the logical zone basis flag as zero.
// - Only the active zone selector in the notch page is writable.
// - Maximum zone count reported in a two-byte field, eleven.
// - Active zone zero means parameters apply to all zones.
// - Zones one to maximum select one zone; zone one outermost.
// - Page 2 and page 3 parameters are held per zone.
// - Start boundary reads selected zone cylinder and head; writes ignored.
// - End boundary reads selected zone cylinder and head; writes ignored.
// - Pages notched bitmap: top bit page 3Fh, bottom bit page 00h.
// - Port page code 19h, length 06h, reserved bytes read zero.
// - Port page byte three low nibble is protocol identifier one.
// - Power page code 1Ah, length 0Ah.
// - Idle enable and idle timer stored but do not affect power saving.
// - Standby enabled: enter standby after timer inactivity.
// - Standby disabled: never enter standby from inactivity.
// - Standby timer counts in 100 ms units.
// - Standby values below sixty minutes act as sixty minutes.
module notch_port_power_mode_pages #(
  parameter int zone_count  = 11,
  parameter int tick_cycles = mode_pages_pkg::tick_cycles
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Page byte access from the command handler
  input  wire logic [5:0]  page_code,
  input  wire logic [4:0]  byte_index,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_en,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             wr_reject,
  // Per-zone geometry table load from firmware
  input  wire logic        geo_load,
  input  wire logic [3:0]  geo_zone,
  input  wire logic [31:0] geo_start,
  input  wire logic [31:0] geo_end,
  // Per-zone page 2 / page 3 parameter port
  input  wire logic        zparam_wr,
  input  wire logic [3:0]  zparam_sel,
  input  wire logic [63:0] zparam_wdata,
  output logic [63:0]      zparam_rdata,
  // Status and power
  output logic [15:0]      active_zone,
  output logic             all_zones,
  input  wire logic        activity,
  output logic             standby
);
  localparam int zw = $clog2(zone_count + 1);

  // Zone 0 entry holds the all-zones parameter set
  logic [31:0] start_tab [0:zone_count];
  logic [31:0] end_tab   [0:zone_count];
  logic [63:0] param_tab [0:zone_count];

  logic [15:0] next_active_zone;
  logic [15:0] pending_zone;
  logic [15:0] next_pending_zone;
  logic        idle_en;
  logic        next_idle_en;
  logic [31:0] idle_tmr;
  logic [31:0] next_idle_tmr;
  logic        stby_en;
  logic        next_stby_en;
  logic [31:0] stby_tmr;
  logic [31:0] next_stby_tmr;
  logic [31:0] stby_limit;
  logic [7:0]  next_rd_data;
  logic        next_wr_reject;
  logic [zw-1:0] zidx;
  logic [zw-1:0] sel_idx;

  // Big-endian byte of a 32-bit field
  function automatic logic [7:0] be32(input logic [31:0] v, input logic [1:0] k);
    be32 = v[8*(3-k) +: 8];
  endfunction

  // Big-endian byte of a 64-bit field
  function automatic logic [7:0] be64(input logic [63:0] v, input logic [2:0] k);
    be64 = v[8*(7-k) +: 8];
  endfunction

  assign zidx      = zw'(active_zone);
  assign sel_idx   = zw'(geo_zone);
  assign all_zones = (active_zone == 16'h0000);

  // Per-zone tables: geometry from firmware, page 2/3 params by zone
  always_ff @(posedge mclk) begin
    if (ce && geo_load && geo_zone <= 4'(zone_count)) begin
      start_tab[sel_idx] <= geo_start;
      end_tab[sel_idx]   <= geo_end;
    end
    if (ce && zparam_wr) begin
      param_tab[zidx] <= zparam_wdata;
    end
  end

  // Per-zone parameter read follows the active zone
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      zparam_rdata <= '0;
    end else if (ce) begin
      zparam_rdata <= param_tab[zidx];
    end
  end

  // Floor on the standby delay
  assign stby_limit = (stby_tmr < mode_pages_pkg::standby_floor_ticks) ?
                      mode_pages_pkg::standby_floor_ticks : stby_tmr;

  // Writes: only writable fields change; everything else is dropped
  always_comb begin
    next_active_zone  = active_zone;
    next_pending_zone = pending_zone;
    next_idle_en      = idle_en;
    next_idle_tmr     = idle_tmr;
    next_stby_en      = stby_en;
    next_stby_tmr     = stby_tmr;
    next_wr_reject    = 1'b0;
    if (wr_en) begin
      case (page_code)
        mode_pages_pkg::notch_page_code: begin
          if (byte_index == mode_pages_pkg::active_zone_hi) begin
            next_pending_zone = {wr_data, pending_zone[7:0]};
          end else if (byte_index == mode_pages_pkg::active_zone_lo) begin
            if ({pending_zone[15:8], wr_data} > mode_pages_pkg::max_zones) begin
              next_wr_reject = 1'b1;
            end else begin
              next_active_zone = {pending_zone[15:8], wr_data};
            end
            next_pending_zone = '0;
          end
        end
        mode_pages_pkg::power_page_code: begin
          if (byte_index == mode_pages_pkg::power_ctl_byte) begin
            next_idle_en = wr_data[mode_pages_pkg::idle_bit_pos];
            next_stby_en = wr_data[mode_pages_pkg::standby_bit_pos];
          end else if (byte_index[4:2] == 3'd1) begin
            next_idle_tmr[8*(3-byte_index[1:0]) +: 8] = wr_data;
          end else if (byte_index[4:2] == 3'd2) begin
            next_stby_tmr[8*(3-byte_index[1:0]) +: 8] = wr_data;
          end
        end
        default: begin
          // Port page is read only; timeout field is expected zero
          next_wr_reject = 1'b0;
        end
      endcase
    end
  end

  // Reads: page bytes assembled from fixed values and state
  always_comb begin
    next_rd_data = 8'h00;
    case (page_code)
      mode_pages_pkg::notch_page_code: begin
        case (byte_index)
          5'h00: next_rd_data = {2'b00, mode_pages_pkg::notch_page_code};
          5'h01: next_rd_data = mode_pages_pkg::notch_page_len;
          mode_pages_pkg::notch_flags_byte: next_rd_data =
            {mode_pages_pkg::zoned_unit_val, mode_pages_pkg::logical_basis_val, 6'h00};
          5'h04: next_rd_data = mode_pages_pkg::max_zones[15:8];
          5'h05: next_rd_data = mode_pages_pkg::max_zones[7:0];
          mode_pages_pkg::active_zone_hi: next_rd_data = active_zone[15:8];
          mode_pages_pkg::active_zone_lo: next_rd_data = active_zone[7:0];
          default: begin
            if (byte_index >= mode_pages_pkg::notched_map_byte) begin
              next_rd_data = be64(mode_pages_pkg::pages_notched, byte_index[2:0]);
            end else if (byte_index >= mode_pages_pkg::end_bound_byte) begin
              next_rd_data = be32(end_tab[zidx], byte_index[1:0]);
            end else if (byte_index >= mode_pages_pkg::start_bound_byte) begin
              next_rd_data = be32(start_tab[zidx], byte_index[1:0]);
            end
          end
        endcase
      end
      mode_pages_pkg::port_page_code: begin
        case (byte_index)
          5'h00: next_rd_data = {2'b00, mode_pages_pkg::port_page_code};
          5'h01: next_rd_data = mode_pages_pkg::port_page_len;
          mode_pages_pkg::port_proto_byte: next_rd_data = {4'h0, mode_pages_pkg::protocol_id};
          default: next_rd_data = 8'h00;
        endcase
      end
      mode_pages_pkg::power_page_code: begin
        case (byte_index)
          5'h00: next_rd_data = {2'b00, mode_pages_pkg::power_page_code};
          5'h01: next_rd_data = mode_pages_pkg::power_page_len;
          mode_pages_pkg::power_ctl_byte: next_rd_data = {6'h00, idle_en, stby_en};
          default: begin
            if (byte_index >= mode_pages_pkg::standby_tmr_byte && byte_index < 5'h0c) begin
              next_rd_data = be32(stby_tmr, byte_index[1:0]);
            end else if (byte_index >= mode_pages_pkg::idle_timer_byte
                         && byte_index < mode_pages_pkg::standby_tmr_byte) begin
              next_rd_data = be32(idle_tmr, byte_index[1:0]);
            end
          end
        endcase
      end
      default: next_rd_data = 8'h00;
    endcase
  end

  // State registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      active_zone  <= 16'h0000;
      pending_zone <= 16'h0000;
      idle_en      <= 1'b0;
      idle_tmr     <= 32'h0000_0000;
      stby_en      <= 1'b0;
      stby_tmr     <= 32'h0000_0000;
      rd_data      <= 8'h00;
      rd_valid     <= 1'b0;
      wr_reject    <= 1'b0;
    end else if (ce) begin
      active_zone  <= next_active_zone;
      pending_zone <= next_pending_zone;
      idle_en      <= next_idle_en;
      idle_tmr     <= next_idle_tmr;
      stby_en      <= next_stby_en;
      stby_tmr     <= next_stby_tmr;
      rd_data      <= rd_en ? next_rd_data : rd_data;
      rd_valid     <= rd_en;
      wr_reject    <= next_wr_reject;
    end
  end

  // Inactivity timer; idle settings deliberately not connected
  standby_timer #(
    .tick_cycles (tick_cycles)
  ) u_standby (
    .mclk        (mclk),
    .rst         (rst),
    .ce          (ce),
    .enable      (stby_en),
    .activity    (activity),
    .limit_ticks (stby_limit),
    .standby     (standby)
  );
endmodule // notch_port_power_mode_pages

// ---- logic/standby_timer.sv ----
`timescale 1ns/1ns
// Counts inactivity in 100 ms ticks and raises standby after the limit
module standby_timer #(
  parameter int tick_cycles = mode_pages_pkg::tick_cycles
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        enable,
  input  wire logic        activity,
  input  wire logic [31:0] limit_ticks,
  output logic             standby
);
  logic [31:0] cyc;
  logic [31:0] ticks;
  logic        next_standby;
  logic [31:0] next_cyc;
  logic [31:0] next_ticks;

  // Next state: activity or disable restart the count
  always_comb begin
    next_cyc     = cyc;
    next_ticks   = ticks;
    next_standby = standby;
    if (!enable || activity) begin
      next_cyc     = '0;
      next_ticks   = '0;
      next_standby = 1'b0;
    end else if (!standby) begin
      if (cyc == 32'(tick_cycles - 1)) begin
        next_cyc   = '0;
        next_ticks = ticks + 32'd1;
        if (ticks + 32'd1 >= limit_ticks) next_standby = 1'b1;
      end else begin
        next_cyc = cyc + 32'd1;
      end
    end
  end

  // Registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cyc     <= '0;
      ticks   <= '0;
      standby <= 1'b0;
    end else if (ce) begin
      cyc     <= next_cyc;
      ticks   <= next_ticks;
      standby <= next_standby;
    end
  end
endmodule // standby_timer

// ---- verif/initiator_model.sv ----
`timescale 1ns/1ns
// Host side issuing mode select and mode sense byte requests
module initiator_model (
  input wire logic  mclk,
  input wire logic  [7:0] rd_data,
  input wire logic  rd_valid,
  output logic [5:0] page_code,
  output logic [4:0] byte_index,
  output logic       wr_en,
  output logic [7:0] wr_data,
  output logic       rd_en
);
  initial {page_code, byte_index, wr_en, wr_data, rd_en} = '0;
  // One byte write (port page bytes 4-5 send zero); released lines go to the inverse of the requested values
  task automatic wr(input logic [5:0] pg, input logic [4:0] ix, input logic [7:0] d);
    @(posedge mclk);
    {page_code, byte_index, wr_en} <= {pg, ix, 1'b1};
    wr_data <= (pg == 6'h19 && ix[4:1] == 4'h2) ? 8'h00 : d;
    @(posedge mclk);
    {page_code, byte_index, wr_en, wr_data} <= {~pg, ~ix, 1'b0, ~d};
  endtask
  // One byte read with a bounded wait for the answer
  task automatic rd(input logic [5:0] pg, input logic [4:0] ix, output logic [7:0] d);
    d = 8'hxx;
    @(posedge mclk);
    {page_code, byte_index, rd_en} <= {pg, ix, 1'b1};
    @(posedge mclk);
    {page_code, byte_index, rd_en} <= {~pg, ~ix, 1'b0};
    for (int n = 0; n < 4; n++) begin
      #1;
      if (rd_valid === 1'b1) begin
        d = rd_data;
        break;
      end
      @(posedge mclk);
    end
  endtask
endmodule // initiator_model

// ---- verif/mode_pages_assertions.sv ----
`timescale 1ns/1ns
// Port-level checks of the mode page block
module mode_pages_assertions #(
  parameter int zone_count = 11
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [5:0]  page_code,
  input wire logic [4:0]  byte_index,
  input wire logic        rd_en,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic        wr_reject,
  input wire logic [15:0] active_zone,
  input wire logic        all_zones,
  input wire logic        activity,
  input wire logic        standby
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Read answers and reads of fixed bytes
  chk_read_answer: assert property (rd_en && ce |=> rd_valid)
    else $error("read not answered");
  chk_flag_byte: assert property (rd_en && ce && page_code == 6'h0c && byte_index == 5'h02
    |=> rd_data == 8'h80) else $error("zone flags wrong");
  chk_zone_max: assert property (rd_en && ce && page_code == 6'h0c && byte_index == 5'h05
    |=> rd_data == 8'h0b) else $error("zone count wrong");
  chk_port_proto: assert property (rd_en && ce && page_code == 6'h19 && byte_index == 5'h03
    |=> rd_data == 8'h01) else $error("protocol id wrong");
  chk_power_code: assert property (rd_en && ce && page_code == 6'h1a && byte_index == 5'h00
    |=> rd_data[5:0] == 6'h1a) else $error("power code wrong");
  // Zone selection
  chk_all_zones: assert property (all_zones == (active_zone == 16'h0000))
    else $error("all zones flag wrong");
  chk_zone_range: assert property (active_zone <= 16'(zone_count))
    else $error("zone beyond maximum");
  chk_reject_hold: assert property (wr_reject |-> $stable(active_zone))
    else $error("refused zone was taken");
  // Standby behaviour
  chk_wake_clear: assert property (activity && ce |=> !standby)
    else $error("standby held over activity");
  chk_quiet_rise: assert property ($rose(standby) |-> !$past(activity))
    else $error("standby rose after activity");
endmodule // mode_pages_assertions

bind notch_port_power_mode_pages mode_pages_assertions #(.zone_count(zone_count)) i_chk (
  .mclk(mclk), .rst(rst), .ce(ce), .page_code(page_code), .byte_index(byte_index),
  .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid), .wr_reject(wr_reject),
  .active_zone(active_zone), .all_zones(all_zones), .activity(activity), .standby(standby));

// ---- verif/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {logic [5:0] pg; logic [4:0] ix; logic [7:0] ex;} row_s;
  localparam row_s rows [16] = '{'{6'h0c, 5'h00, 8'h0c}, '{6'h0c, 5'h01, 8'h16},
    '{6'h0c, 5'h02, 8'h80}, '{6'h0c, 5'h03, 8'h00}, '{6'h0c, 5'h04, 8'h00},
    '{6'h0c, 5'h05, 8'h0b}, '{6'h0c, 5'h10, 8'h00}, '{6'h0c, 5'h17, 8'h0c},
    '{6'h19, 5'h01, 8'h06}, '{6'h19, 5'h02, 8'h00}, '{6'h19, 5'h03, 8'h01},
    '{6'h19, 5'h06, 8'h00}, '{6'h19, 5'h07, 8'h00}, '{6'h1a, 5'h00, 8'h1a},
    '{6'h1a, 5'h01, 8'h0a}, '{6'h19, 5'h00, 8'h19}};
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [5:0]  page_code;
  logic [4:0]  byte_index;
  logic        wr_en, rd_en, rd_valid, wr_reject, all_zones, standby;
  logic [7:0]  wr_data, rd_data, d;
  logic        geo_load = 1'b0, zparam_wr = 1'b0, activity = 1'b0;
  logic [3:0]  geo_zone = 4'h0;
  logic [31:0] geo_start = 32'h0, geo_end = 32'h0;
  logic [63:0] zparam_wdata = 64'h0, zparam_rdata;
  logic [15:0] active_zone;
  int          failures = 0, checks_done = 0, n;
  always #5 mclk = ~mclk;
  notch_port_power_mode_pages #(.zone_count(11), .tick_cycles(1)) i_notch_port_power_mode_pages (
    .mclk(mclk), .rst(rst), .ce(ce), .page_code(page_code), .byte_index(byte_index),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_reject(wr_reject), .geo_load(geo_load), .geo_zone(geo_zone), .geo_start(geo_start),
    .geo_end(geo_end), .zparam_wr(zparam_wr), .zparam_sel(4'h0), .zparam_wdata(zparam_wdata),
    .zparam_rdata(zparam_rdata), .active_zone(active_zone), .all_zones(all_zones),
    .activity(activity), .standby(standby));
  initiator_model host (.mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid),
    .page_code(page_code), .byte_index(byte_index), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en));
  // Compare tasks and verdict
  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_wide(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Active zone select: high byte then committing low byte
  task automatic sel(input logic [15:0] z);
    host.wr(6'h0c, 5'h06, z[15:8]);
    host.wr(6'h0c, 5'h07, z[7:0]);
    #1;
  endtask
  task automatic pulse_activity();
    @(posedge mclk) activity <= 1'b1;
    @(posedge mclk) activity <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    #1 cmp_wide("all_zones", 64'h1, all_zones);
    foreach (rows[i]) begin
      host.rd(rows[i].pg, rows[i].ix, d);
      cmp_byte("page byte", rows[i].ex, d);
    end
    // Fixed fields and the port page ignore writes
    host.wr(6'h0c, 5'h05, 8'h22);
    host.wr(6'h19, 5'h02, 8'h55);
    host.wr(6'h19, 5'h04, 8'h00);
    host.rd(6'h0c, 5'h05, d);
    cmp_byte("max zones", 8'h0b, d);
    host.rd(6'h19, 5'h02, d);
    cmp_byte("port reserved", 8'h00, d);
    // Boundaries of zone three, host writes ignored
    @(posedge mclk) {geo_load, geo_zone, geo_start, geo_end} <= {1'b1, 4'h3, 64'h00123405_00126709};
    @(posedge mclk) geo_load <= 1'b0;
    sel(16'h0003);
    cmp_wide("active_zone", 64'h3, active_zone);
    host.wr(6'h0c, 5'h08, 8'hff);
    host.wr(6'h0c, 5'h0f, 8'hff);
    for (int i = 0; i < 8; i++) begin
      host.rd(6'h0c, 5'(8 + i), d);
      cmp_byte("boundary", 8'(64'h00123405_00126709 >> (56 - 8 * i)), d);
    end
    // Zone above the maximum is refused
    sel(16'h000c);
    cmp_wide("wr_reject", 64'h1, wr_reject);
    cmp_wide("kept zone", 64'h3, active_zone);
    // Per-zone parameter sets
    for (int z = 1; z < 3; z++) begin
      sel(16'(z));
      @(posedge mclk) {zparam_wr, zparam_wdata} <= {1'b1, 64'h5a00 + 64'(z)};
      @(posedge mclk) zparam_wr <= 1'b0;
    end
    sel(16'h0001);
    repeat (2) @(posedge mclk);
    #1 cmp_wide("zone params", 64'h5a01, zparam_rdata);
    sel(16'h0000);
    cmp_wide("all_zones", 64'h1, all_zones);
    // Clock enable low freezes the zone selection
    @(posedge mclk) ce <= 1'b0;
    sel(16'h0005);
    cmp_wide("frozen zone", 64'h0, active_zone);
    @(posedge mclk) ce <= 1'b1;
    sel(16'h0005);
    cmp_wide("active_zone", 64'h5, active_zone);
    // Reset in mid-run returns to all zones
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 cmp_wide("reset zone", 64'h0, active_zone);
    cmp_wide("reset all_zones", 64'h1, all_zones);
    cmp_wide("reset wr_reject", 64'h0, wr_reject);
    cmp_wide("reset params", 64'h0, zparam_rdata);
    cmp_wide("reset standby", 64'h0, standby);
    // Idle fields stored, standby untouched
    host.wr(6'h1a, 5'h03, 8'h02);
    host.wr(6'h1a, 5'h07, 8'h05);
    host.rd(6'h1a, 5'h03, d);
    cmp_byte("idle enable", 8'h02, d);
    host.rd(6'h1a, 5'h07, d);
    cmp_byte("idle timer", 8'h05, d);
    // Short standby timer takes the sixty minute floor
    host.wr(6'h1a, 5'h03, 8'h03);
    host.wr(6'h1a, 5'h0b, 8'h01);
    pulse_activity();
    for (n = 0; n < 40000 && standby !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    cmp_wide("standby delay", 64'h1, 64'(n >= 35995 && n <= 36005));
    pulse_activity();
    #1 cmp_wide("standby", 64'h0, standby);
    // Disabled standby never comes
    host.wr(6'h1a, 5'h03, 8'h00);
    pulse_activity();
    repeat (36100) @(posedge mclk);
    #1 cmp_wide("standby", 64'h0, standby);
    conclude();
  end
endmodule // tb_top
